// *** hdl/pdeo_defs.vh ***
`ifndef PDEO_DEFS_VH
`define PDEO_DEFS_VH

// Mask thresholds for the segment port pin pairs.
`define PDEO_PM_PIN76     3'h1
`define PDEO_PM_PIN54     3'h2
`define PDEO_PM_PIN32     3'h3
`define PDEO_PM_PIN10     3'h4
// Width of the segment port mask field.
`define PDEO_PM_W         3
// Second port bit positions.
`define PDEO_E_DIVIDED_CLOCK_PIN       7
`define PDEO_E_USI_DO     6
`define PDEO_E_USI_DI     5
`define PDEO_E_USI_CLK    4
`define PDEO_E_AIN_NEG    3
`define PDEO_E_XCK        2
// Pins of the second port that feed pin-change detection (bits 7..1).
`define PDEO_PCINT_MASK   8'hfe
// Reset value of all override outputs.
`define PDEO_RST_BYTE     8'h00
// Width of the clock divider prescale selector.
`define PDEO_DIV_W        4

`endif

// *** hdl/pdeo_clk_div.v ***
`timescale 1ns/1ps
`include "pdeo_defs.vh"

// Divides the system clock by 2^(sel+1); it keeps running under the port reset.
module pdeo_clk_div (
    // Clock.
    input  wire                     i_clk,
    // Power-on reset only, so the port reset never stops the divided clock.
    input  wire                     i_por_n,
    // Divider selection.
    input  wire [`PDEO_DIV_W-1:0]   i_sel,
    // Divided clock level.
    output reg                      o_div_clk
);

    reg [15:0] count;

    // Free running counter; the selected bit becomes the divided clock.
    always @(posedge i_clk or negedge i_por_n) begin
        if (!i_por_n) begin
            count     <= 16'h0000;
            o_div_clk <= 1'b0;
        end else begin
            count     <= count + 16'h0001;
            o_div_clk <= count[i_sel];
        end
    end

endmodule // pdeo_clk_div

// *** hdl/pdeo_port_mux.v ***
`timescale 1ns/1ps
`include "pdeo_defs.vh"

// Behaviour
// - Pins 7,6 need LCD on and mask>1; pins 5,4 need mask>2.
// - Pins 3,2 need LCD on and mask>3; pin 0 needs mask>4.
// - Pin 1: pull/dir need mask>4; input gate uses LCD or irq-zero enable.
// - Segment pins: override values zero except pin 1 input gate; output value never overridden.
// - Segment bit 0 feeds timer capture; bit 1 feeds external irq zero.
// - With clock-out fuse, second port bit 7 drives divided clock.
// - Divided clock on o_divided_clock_pin stays active during device reset; bit 7 pad controls are reset.
// - Second port bits 7..1 feed pin-change detection logic.
// - USART clock pin is output when direction bit set, else input.
// - USART clock pin function acts only in synchronous mode.
// - Second port bit 3 goes straight to comparator negative input.
// - Second port bit 2 goes straight to comparator positive input.
// - Second port bit 6 carries serial interface data out when used.
// - Second port bit 5 feeds serial data in and two-wire data.
// - Second port bit 4 is serial interface clock and two-wire clock.
module pdeo_port_mux (
    // Clock and resets.
    input  wire                     i_clk,
    input  wire                     i_reset_n,
    input  wire                     i_por_n,
    // Segment port registers and pad input.
    input  wire [7:0]               i_d_port_value,
    input  wire [7:0]               i_d_direction,
    input  wire [7:0]               i_d_pin_in,
    input  wire                     i_pullup_disable,
    // LCD control.
    input  wire                     i_lcd_driver_on,
    input  wire [`PDEO_PM_W-1:0]    i_segment_port_mask,
    input  wire                     i_external_irq_zero_enable,
    // Second port registers and pad input.
    input  wire [7:0]               i_e_port_value,
    input  wire [7:0]               i_e_direction,
    input  wire [7:0]               i_e_pin_in,
    // Clock output control.
    input  wire                     i_clock_out_fuse,
    input  wire [`PDEO_DIV_W-1:0]   i_clock_div_sel,
    // Peripheral controls.
    input  wire                     i_usart_sync_mode,
    input  wire                     i_usart_sync_clock_out,
    input  wire                     i_usi_three_wire,
    input  wire                     i_usi_two_wire,
    input  wire                     i_usi_data_out,
    // Segment port pad controls.
    output reg  [7:0]               o_d_pullup,
    output reg  [7:0]               o_d_drive_en,
    output reg  [7:0]               o_d_drive_value,
    output reg  [7:0]               o_d_input_gate,
    output reg  [7:0]               o_d_segment_analog,
    // Segment port peripheral inputs.
    output reg                      o_timer_capture_input,
    output reg                      o_external_irq_zero,
    // Second port pad controls.
    output reg  [7:0]               o_e_pullup,
    output reg  [7:0]               o_e_drive_en,
    output reg  [7:0]               o_e_drive_value,
    // Second port peripheral inputs.
    output reg  [7:0]               o_pin_change_source,
    output reg                      o_comparator_negative_in,
    output reg                      o_comparator_positive_in,
    output reg                      o_usart_sync_clock_in,
    output reg                      o_usart_sync_clock_is_out,
    output reg                      o_usi_serial_in,
    output reg                      o_usi_shift_clock,
    // Divided clock pin, alive across the port reset.
    output reg                      o_divided_clock_pin
);

    wire       div_clk;
    reg  [7:0] d_ovr_en;
    reg  [7:0] d_in_ovr_en;
    reg  [7:0] d_in_ovr_val;
    reg  [7:0] next_d_pullup;
    reg  [7:0] next_d_drive_en;
    reg  [7:0] next_d_drive_value;
    reg  [7:0] next_d_input_gate;
    reg  [7:0] next_e_pullup;
    reg  [7:0] next_e_drive_en;
    reg  [7:0] next_e_drive_value;
    reg        xck_active;
    integer    k;
    integer    j;

    // Divider runs on power-on reset only so the clock survives a port reset.
    pdeo_clk_div u_div (
        .i_clk     (i_clk),
        .i_por_n   (i_por_n),
        .i_sel     (i_clock_div_sel),
        .o_div_clk (div_clk)
    );

    // Segment port override enables per pin pair.
    always @* begin
        d_ovr_en[7] = i_lcd_driver_on & (i_segment_port_mask > `PDEO_PM_PIN76);
        d_ovr_en[6] = d_ovr_en[7];
        d_ovr_en[5] = i_lcd_driver_on & (i_segment_port_mask > `PDEO_PM_PIN54);
        d_ovr_en[4] = d_ovr_en[5];
        d_ovr_en[3] = i_lcd_driver_on & (i_segment_port_mask > `PDEO_PM_PIN32);
        d_ovr_en[2] = d_ovr_en[3];
        d_ovr_en[1] = i_lcd_driver_on & (i_segment_port_mask > `PDEO_PM_PIN10);
        d_ovr_en[0] = d_ovr_en[1];
        d_in_ovr_en  = d_ovr_en;
        d_in_ovr_val = 8'h00;
        d_in_ovr_en[1]  = i_lcd_driver_on | i_external_irq_zero_enable;
        d_in_ovr_val[1] = i_lcd_driver_on & i_external_irq_zero_enable;
    end

    // Segment port pad muxing; override values are zero except the pin 1 input gate.
    always @* begin
        for (k = 0; k < 8; k = k + 1) begin
            next_d_pullup[k] = d_ovr_en[k] ? 1'b0 :
                               (i_d_port_value[k] & ~i_d_direction[k] & ~i_pullup_disable);
            next_d_drive_en[k]    = d_ovr_en[k] ? 1'b0 : i_d_direction[k];
            next_d_drive_value[k] = i_d_port_value[k];
            next_d_input_gate[k]  = d_in_ovr_en[k] ? d_in_ovr_val[k] : 1'b1;
        end
    end

    // Second port pad muxing for clock, USART clock and serial interface.
    always @* begin
        xck_active = i_usart_sync_mode;
        for (j = 0; j < 8; j = j + 1) begin
            next_e_pullup[j] = i_e_port_value[j] & ~i_e_direction[j] & ~i_pullup_disable;
            next_e_drive_en[j]    = i_e_direction[j];
            next_e_drive_value[j] = i_e_port_value[j];
        end
        // The USART clock pin direction follows its direction bit.
        if (xck_active && i_e_direction[`PDEO_E_XCK]) begin
            next_e_drive_value[`PDEO_E_XCK] = i_usart_sync_clock_out;
            next_e_pullup[`PDEO_E_XCK]      = 1'b0;
        end
        if (i_usi_three_wire) begin
            next_e_drive_value[`PDEO_E_USI_DO] = i_usi_data_out;
        end
        // Two-wire mode: lines only pull low, so drive value is zero.
        if (i_usi_two_wire) begin
            next_e_pullup[`PDEO_E_USI_DI]      = 1'b0;
            next_e_drive_value[`PDEO_E_USI_DI] = 1'b0;
            next_e_drive_value[`PDEO_E_USI_CLK] = 1'b0;
            next_e_drive_en[`PDEO_E_USI_DI]  = ~i_e_port_value[`PDEO_E_USI_DI]
                                               & i_e_direction[`PDEO_E_USI_DI];
            next_e_drive_en[`PDEO_E_USI_CLK] = ~i_e_port_value[`PDEO_E_USI_CLK]
                                               & i_e_direction[`PDEO_E_USI_CLK];
        end
        if (i_clock_out_fuse) begin
            next_e_drive_en[`PDEO_E_DIVIDED_CLOCK_PIN] = 1'b1;
            next_e_drive_value[`PDEO_E_DIVIDED_CLOCK_PIN] = div_clk;
            next_e_pullup[`PDEO_E_DIVIDED_CLOCK_PIN]   = 1'b0;
        end
    end

    // Divided clock pin is held outside the port reset domain.
    always @(posedge i_clk or negedge i_por_n) begin
        if (!i_por_n) begin
            o_divided_clock_pin <= 1'b0;
        end else begin
            o_divided_clock_pin <= i_clock_out_fuse ? div_clk
                                   : i_e_port_value[`PDEO_E_DIVIDED_CLOCK_PIN];
        end
    end

    // Registered pad controls and peripheral inputs.
    always @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            o_d_pullup                <= `PDEO_RST_BYTE;
            o_d_drive_en              <= `PDEO_RST_BYTE;
            o_d_drive_value           <= `PDEO_RST_BYTE;
            o_d_input_gate            <= `PDEO_RST_BYTE;
            o_d_segment_analog        <= `PDEO_RST_BYTE;
            o_timer_capture_input     <= 1'b0;
            o_external_irq_zero       <= 1'b0;
            o_e_pullup                <= `PDEO_RST_BYTE;
            o_e_drive_en              <= `PDEO_RST_BYTE;
            o_e_drive_value           <= `PDEO_RST_BYTE;
            o_pin_change_source       <= `PDEO_RST_BYTE;
            o_comparator_negative_in  <= 1'b0;
            o_comparator_positive_in  <= 1'b0;
            o_usart_sync_clock_in     <= 1'b0;
            o_usart_sync_clock_is_out <= 1'b0;
            o_usi_serial_in           <= 1'b0;
            o_usi_shift_clock         <= 1'b0;
        end else begin
            o_d_pullup         <= next_d_pullup;
            o_d_drive_en       <= next_d_drive_en;
            o_d_drive_value    <= next_d_drive_value;
            o_d_input_gate     <= next_d_input_gate;
            o_d_segment_analog <= d_ovr_en;
            o_timer_capture_input <= i_d_pin_in[0] & next_d_input_gate[0];
            o_external_irq_zero   <= i_d_pin_in[1] & next_d_input_gate[1];
            o_e_pullup      <= next_e_pullup;
            o_e_drive_en    <= next_e_drive_en;
            o_e_drive_value <= next_e_drive_value;
            o_pin_change_source <= i_e_pin_in & `PDEO_PCINT_MASK;
            o_comparator_negative_in <= i_e_pin_in[`PDEO_E_AIN_NEG];
            o_comparator_positive_in <= i_e_pin_in[`PDEO_E_XCK];
            o_usart_sync_clock_in <= xck_active & ~i_e_direction[`PDEO_E_XCK]
                                     & i_e_pin_in[`PDEO_E_XCK];
            o_usart_sync_clock_is_out <= xck_active & i_e_direction[`PDEO_E_XCK];
            o_usi_serial_in   <= i_e_pin_in[`PDEO_E_USI_DI];
            o_usi_shift_clock <= i_e_pin_in[`PDEO_E_USI_CLK];
        end
    end

endmodule // pdeo_port_mux

// *** test/pdeo_pad_model.sv ***
`timescale 1ns/1ps
// Pad and board model: a driven pad shows the design's value, else the board level.
module pdeo_pad_model (
    // Pad controls from the port mux.
    input  wire logic [7:0] i_drive_en,
    input  wire logic [7:0] i_drive_value,
    // Level that the board puts on each pin.
    input  wire logic [7:0] i_board,
    // Level seen back at the pad input.
    output logic      [7:0] o_level
);
    // Each pin resolves on its own, so a stuck enable shows up as a wrong level.
    assign o_level = (i_drive_en & i_drive_value) | (~i_drive_en & i_board);
endmodule // pdeo_pad_model

// *** test/pdeo_port_mux_assertions.sv ***
`timescale 1ns/1ps
// Port mux checker; one cycle of latency from inputs to outputs.
module pdeo_port_mux_checker (
    // Clock, resets and controls.
    input wire logic       i_clk, i_reset_n, i_por_n, i_lcd_driver_on,
    input wire logic       i_external_irq_zero_enable, i_clock_out_fuse,
    input wire logic [2:0] i_segment_port_mask,
    input wire logic [3:0] i_clock_div_sel,
    input wire logic [7:0] i_d_pin_in, i_e_pin_in,
    // Watched outputs.
    input wire logic [7:0] o_d_segment_analog, o_d_drive_en, o_d_pullup, o_d_drive_value,
    input wire logic [7:0] o_d_input_gate, o_e_drive_en, o_pin_change_source,
    input wire logic       o_timer_capture_input, o_comparator_negative_in,
    input wire logic       o_comparator_positive_in, o_usi_serial_in, o_usi_shift_clock,
    input wire logic       o_divided_clock_pin
);
    logic live;
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_reset_n);
    // Marks cycles whose previous edge was already out of reset.
    always @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) live <= 1'b0;
        else live <= 1'b1;
    end
    sequence s_fast_div;
        (i_clock_out_fuse && i_clock_div_sel == 4'h0) [*8];
    endsequence
    chk_seg_pins_76: assert property (live |-> o_d_segment_analog[7:6] ==
        {2{$past(i_lcd_driver_on) && $past(i_segment_port_mask) > 3'h1}}) else $error("pins 7,6");
    chk_seg_pins_54: assert property (live |-> o_d_segment_analog[5:4] ==
        {2{$past(i_lcd_driver_on) && $past(i_segment_port_mask) > 3'h2}}) else $error("pins 5,4");
    chk_seg_pins_30: assert property (live |-> {o_d_segment_analog[3:2], o_d_segment_analog[0]} ==
        {{2{$past(i_lcd_driver_on) && $past(i_segment_port_mask) > 3'h3}},
        $past(i_lcd_driver_on) && $past(i_segment_port_mask) > 3'h4}) else $error("pins 3..0");
    chk_pin1_gate: assert property (live |-> o_d_input_gate[1] ==
        ($past(i_lcd_driver_on) || $past(i_external_irq_zero_enable) ?
        $past(i_lcd_driver_on) && $past(i_external_irq_zero_enable) : 1'b1)) else $error("gate 1");
    chk_seg_quiet: assert property ((o_d_segment_analog & (o_d_drive_en | o_d_pullup |
        (o_d_input_gate & 8'hfd))) == 8'h00) else $error("segment pad");
    chk_capture_route: assert property (live |-> o_timer_capture_input ==
        ($past(i_d_pin_in[0]) & o_d_input_gate[0])) else $error("capture");
    chk_clock_fuse: assert property ($past(i_clock_out_fuse) && live |-> o_e_drive_en[7])
        else $error("clock pin enable");
    chk_div_alive: assert property (@(posedge i_clk) disable iff (!i_por_n)
        s_fast_div |-> !$stable(o_divided_clock_pin)) else $error("divided clock");
    chk_pin_change: assert property (live |-> o_pin_change_source ==
        ($past(i_e_pin_in) & 8'hfe)) else $error("pin change");
    chk_e_inputs: assert property (live |-> {o_comparator_negative_in, o_comparator_positive_in,
        o_usi_serial_in, o_usi_shift_clock} == {$past(i_e_pin_in[3]), $past(i_e_pin_in[2]),
        $past(i_e_pin_in[5]), $past(i_e_pin_in[4])}) else $error("e inputs");
endmodule // pdeo_port_mux_checker
bind pdeo_port_mux pdeo_port_mux_checker pdeo_port_mux_checker_i (.*);

// *** test/tb_port_d_e_alt_function_override.sv ***
`timescale 1ns/1ps
module tb_port_d_e_alt_function_override;
    // Design inputs.
    logic       i_clk = 0, i_reset_n = 0, i_por_n = 0, i_pullup_disable = 0;
    logic       i_lcd_driver_on = 0, i_external_irq_zero_enable = 0, i_clock_out_fuse = 0;
    logic       i_usart_sync_mode = 0, i_usart_sync_clock_out = 0, i_usi_three_wire = 0;
    logic       i_usi_two_wire = 0, i_usi_data_out = 0;
    logic [2:0] i_segment_port_mask = 3'h0;
    logic [3:0] i_clock_div_sel = 4'h0;
    logic [7:0] i_d_port_value = 8'h00, i_d_direction = 8'h00, i_e_port_value = 8'h00;
    logic [7:0] i_e_direction = 8'h00, board_d = 8'h00, board_e = 8'h00, e, v;
    wire  [7:0] i_d_pin_in, i_e_pin_in, o_d_pullup, o_d_drive_en, o_d_drive_value;
    wire  [7:0] o_d_input_gate, o_d_segment_analog, o_e_pullup, o_e_drive_en;
    wire  [7:0] o_e_drive_value, o_pin_change_source;
    wire        o_timer_capture_input, o_external_irq_zero, o_comparator_negative_in;
    wire        o_comparator_positive_in, o_usart_sync_clock_in, o_usart_sync_clock_is_out;
    wire        o_usi_serial_in, o_usi_shift_clock, o_divided_clock_pin;
    int         n_errors = 0, check_count = 0, cyc = 0, m;
    pdeo_port_mux pdeo_port_mux_i (.*);
    pdeo_pad_model pad_d_i (.i_drive_en(o_d_drive_en), .i_drive_value(o_d_drive_value),
        .i_board(board_d), .o_level(i_d_pin_in));
    pdeo_pad_model pad_e_i (.i_drive_en(o_e_drive_en), .i_drive_value(o_e_drive_value),
        .i_board(board_e), .o_level(i_e_pin_in));
    // Clock and hang guard.
    initial forever #10 i_clk = ~i_clk;
    always @(posedge i_clk) begin
        cyc <= cyc + 1;
        if (cyc == 3000) begin
            n_errors++;
            complete_run;
        end
    end
    task complete_run;
        if (n_errors == 0 && check_count > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    task chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
        check_count++;
        if (got !== exp) begin
            n_errors++;
            $display("[ERR] %s expected %h seen %h", nm, exp, got);
        end
    endtask
    // Two edges so pad feedback has settled before looking.
    task step;
        repeat (2) @(posedge i_clk);
        #1;
    endtask
    task toggles;
        v = {7'h0, o_divided_clock_pin};
        @(posedge i_clk);
        #1;
        chk("divclk", ~v & 8'h01, {7'h0, o_divided_clock_pin});
    endtask
    initial begin
        // Power-on released early; divided clock must run under the port reset.
        @(posedge i_clk);
        i_por_n <= 1;
        i_clock_out_fuse <= 1;
        repeat (8) @(posedge i_clk);
        #1;
        chk("rst_den", 8'h00, o_d_drive_en);
        toggles;
        @(posedge i_clk);
        i_reset_n <= 1;
        i_lcd_driver_on <= 1;
        i_d_direction <= 8'hff;
        i_d_port_value <= 8'hff;
        for (m = 0; m < 8; m++) begin
            @(posedge i_clk);
            i_segment_port_mask <= m[2:0];
            step;
            e = {{2{m > 1}}, {2{m > 2}}, {2{m > 3}}, {2{m > 4}}};
            chk("seg", e, o_d_segment_analog);
            chk("d_den", ~e, o_d_drive_en);
            chk("d_dval", 8'hff, o_d_drive_value);
            chk("d_gate", ~e & 8'hfd, o_d_input_gate);
        end
        // Pin 1 gating for every LCD and interrupt-enable pairing.
        for (m = 0; m < 4; m++) begin
            @(posedge i_clk);
            {i_lcd_driver_on, i_external_irq_zero_enable} <= m[1:0];
            i_segment_port_mask <= 3'h0;
            i_d_direction <= 8'h00;
            i_pullup_disable <= m[0];
            board_d <= 8'hff;
            step;
            chk("irq0", {7'h0, m == 0 || m == 3}, {7'h0, o_external_irq_zero});
            chk("capture", 8'h01, {7'h0, o_timer_capture_input});
            chk("d_pull", m[0] ? 8'h00 : 8'hff, o_d_pullup);
        end
        for (m = 0; m < 2; m++) begin
            @(posedge i_clk);
            v = m ? 8'h4a : 8'hb5;
            board_e <= v;
            i_clock_out_fuse <= 0;
            step;
            chk("pcint", v & 8'hfe, o_pin_change_source);
            chk("e_in", {4'h0, v[3], v[2], v[5], v[4]}, {4'h0, o_comparator_negative_in,
                o_comparator_positive_in, o_usi_serial_in, o_usi_shift_clock});
        end
        @(posedge i_clk);
        i_clock_out_fuse <= 1;
        step;
        chk("clk_en", 8'h01, {7'h0, o_e_drive_en[7]});
        toggles;
        @(posedge i_clk);
        i_usart_sync_mode <= 1;
        i_usart_sync_clock_out <= 1;
        i_e_direction <= 8'h04;
        board_e <= 8'h00;
        step;
        chk("xck_out", 8'h03, {6'h0, o_usart_sync_clock_is_out, o_e_drive_value[2]});
        @(posedge i_clk);
        i_e_direction <= 8'h00;
        board_e <= 8'h04;
        step;
        chk("xck_in", 8'h01, {6'h0, o_usart_sync_clock_is_out, o_usart_sync_clock_in});
        @(posedge i_clk);
        i_usart_sync_mode <= 0;
        i_e_direction <= 8'h04;
        step;
        chk("xck_off", 8'h00, {6'h0, o_usart_sync_clock_is_out, o_e_drive_value[2]});
        @(posedge i_clk);
        i_usi_three_wire <= 1;
        i_usi_data_out <= 1;
        step;
        chk("usi_do", 8'h01, {7'h0, o_e_drive_value[6]});
        @(posedge i_clk);
        i_usi_three_wire <= 0;
        i_usi_two_wire <= 1;
        i_e_direction <= 8'hff;
        step;
        chk("twi_pad", 8'h0c, {4'h0, o_e_drive_en[5:4], o_e_drive_value[5:4]});
        chk("twi_pull", 8'h00, {7'h0, o_e_pullup[5]});
        complete_run;
    end
endmodule // tb_port_d_e_alt_function_override
